// File: logic/ast_slot_timer.sv
`timescale 1ns/1ns
// Summary of operation
// - Sample counter is 11 bits, stepped at 48 kHz from reference clock.
// - Sample counter runs 0 to 1279 then returns to 0.
// - 12-bit slot counter advances when sample counter rolls over.
// - Slot counter runs 0 to 2249 then wraps to 0.
// - Live slot and sample values read together in one 32-bit register.
// - Slot pulse is low for first sample period of every slot.
// - Control bit 7 chooses push-pull (0) or open-drain (1) slot pulse.
// - Control bit 2 enables automatic receive sleep on the single rx_sleep output.
// - Mode field: 00 manual, 01 acquire, 10 track, 11 reserved.
// - With sleep on, receivers doze in inactive slot at doze sample.
// - Receivers wake when sample counter reaches wake sample.
// - Second pulse rising edge captures both counters, upper bits zero.
// - Slot adjustment is added to slot counter with the next applied nudge, or alone at a track-mode trigger point.
// - Sample adjustment applied only in manual and reserved (11) modes, ignored otherwise.
// - Pending adjustments apply when sample counter equals trigger value.
// - After reset both counters free-run from zero unsynchronised.
// - After a nudge both adjustment registers clear; done event fires except on a track nudge with zero slot adjustment.
// - Track mode computes clamped correction at each second pulse.
// - Acquire mode corrects from latched capture then fires done event.
// - Slot counter wraps on nudges; host keeps sample result in range.
module ast_slot_timer #(
    parameter int REF_HZ = ast_pkg::REF_HZ_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ast_pkg::ast_bus_req_type bus_req,
    output ast_pkg::ast_bus_rsp_type bus_rsp,
    input wire logic reference_clock_in,
    input wire logic utc_second_pulse_in,
    input wire logic rx_slot_active,
    output logic slot_pulse_n_out_o,
    output logic slot_pulse_n_out_oe,
    output logic rx_sleep,
    output logic nudge_done
);
    localparam int REF_DIV = REF_HZ / ast_pkg::SAMPLE_RATE_HZ;
    localparam int DIV_W = (REF_DIV > 1) ? $clog2(REF_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REF_DIV - 1);
    if (REF_DIV < 1 || REF_DIV * ast_pkg::SAMPLE_RATE_HZ != REF_HZ) begin : g_bad_ref
        $error("REF_HZ must be a whole multiple of the sample rate");
    end

    // Reference clock sampling and 48 kHz tick
    logic ref_s1_ff, ref_s2_ff, ref_prev_ff, tick_ff;
    logic nxt_ref_s1, nxt_ref_s2, nxt_ref_prev, nxt_tick;
    logic [DIV_W-1:0] div_ff, nxt_div;

    always_comb begin
        nxt_ref_s1 = reference_clock_in;
        nxt_ref_s2 = ref_s1_ff;
        nxt_ref_prev = ref_s2_ff;
        nxt_div = div_ff;
        nxt_tick = 1'b0;
        if (ref_s2_ff && !ref_prev_ff) begin
            if (div_ff == DIV_LAST) begin
                nxt_div = '0;
                nxt_tick = 1'b1;
            end else begin
                nxt_div = div_ff + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_s1_ff <= 1'b0;
            ref_s2_ff <= 1'b0;
            ref_prev_ff <= 1'b0;
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            ref_s1_ff <= nxt_ref_s1;
            ref_s2_ff <= nxt_ref_s2;
            ref_prev_ff <= nxt_ref_prev;
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

    // Second pulse synchroniser
    logic utc_s1_ff, utc_s2_ff, utc_prev_ff;
    logic utc_rise;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            utc_s1_ff <= 1'b0;
            utc_s2_ff <= 1'b0;
            utc_prev_ff <= 1'b0;
        end else begin
            utc_s1_ff <= utc_second_pulse_in;
            utc_s2_ff <= utc_s1_ff;
            utc_prev_ff <= utc_s2_ff;
        end
    end

    assign utc_rise = utc_s2_ff && !utc_prev_ff;

    // Counters, registers and nudge engine
    logic [10:0] sample_ff, nxt_sample;
    logic [11:0] slot_ff, nxt_slot;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [15:0] doze_ff, nxt_doze, wake_ff, nxt_wake, slot_adj_ff, nxt_slot_adj;
    logic [15:0] tick_adj_ff, nxt_tick_adj, trig_ff, nxt_trig, max_ff, nxt_max;
    logic [31:0] capt_ff, nxt_capt;
    logic man_pend_ff, nxt_man_pend, acq_done_ff, nxt_acq_done, trk_pend_ff, nxt_trk_pend;
    logic signed [12:0] trk_corr_ff, nxt_trk_corr;
    logic sleep_ff, nxt_sleep, done_ff, nxt_done, pin_o_ff, nxt_pin_o, pin_oe_ff, nxt_pin_oe;
    ast_pkg::ast_bus_rsp_type rsp_ff, nxt_rsp;

    logic [1:0] mode;
    logic is_acq, is_trk, is_man, trig, apply, slot_apply;
    logic [10:0] sample_inc;
    logic [11:0] slot_inc;
    logic signed [12:0] samp_adj, s_now, corr, max_s;
    logic signed [17:0] slot_sum, slot_mod;

    always_comb begin
        mode = ctrl_ff[ast_pkg::CTRL_MODE_LSB +: 2];
        is_acq = (mode == ast_pkg::MODE_ACQUIRE);
        is_trk = (mode == ast_pkg::MODE_TRACK);
        is_man = !is_acq && !is_trk;
        nxt_ctrl = ctrl_ff;
        nxt_doze = doze_ff;
        nxt_wake = wake_ff;
        nxt_slot_adj = slot_adj_ff;
        nxt_tick_adj = tick_adj_ff;
        nxt_trig = trig_ff;
        nxt_max = max_ff;
        nxt_capt = capt_ff;
        nxt_man_pend = man_pend_ff;
        nxt_acq_done = acq_done_ff && is_acq;
        nxt_trk_pend = trk_pend_ff && is_trk;
        nxt_trk_corr = trk_corr_ff;
        nxt_done = 1'b0;
        nxt_sleep = sleep_ff;
        sample_inc = (sample_ff == ast_pkg::SAMPLE_LAST) ? '0 : sample_ff + 11'h001;
        slot_inc = slot_ff;
        if (sample_ff == ast_pkg::SAMPLE_LAST) begin
            slot_inc = (slot_ff == ast_pkg::SLOT_LAST) ? '0 : slot_ff + 12'h001;
        end
        trig = tick_ff && (sample_ff == trig_ff[ast_pkg::SAMPLE_W-1:0]);
        samp_adj = '0;
        if (is_man) begin
            samp_adj = tick_adj_ff[12:0];
        end else if (is_acq) begin
            samp_adj = -$signed({2'b00, capt_ff[ast_pkg::SAMPLE_W-1:0]});
        end else begin
            samp_adj = trk_corr_ff;
        end
        apply = trig && ((is_man && man_pend_ff) || (is_acq && !acq_done_ff) || (is_trk && trk_pend_ff));
        // slot nudge rides every applied nudge, or alone in track
        slot_apply = apply || (trig && is_trk && slot_adj_ff != '0);
        slot_sum = $signed({6'b000000, slot_inc}) + $signed({{2{slot_adj_ff[15]}}, slot_adj_ff});
        slot_mod = slot_sum % $signed(18'(ast_pkg::SLOTS_PER_FRAME));
        if (slot_mod < 0) begin
            slot_mod = slot_mod + 18'(ast_pkg::SLOTS_PER_FRAME);
        end
        nxt_sample = sample_ff;
        nxt_slot = slot_ff;
        // counters step on the sample tick
        if (tick_ff) begin
            nxt_sample = apply ? 11'($signed({2'b00, sample_inc}) + samp_adj) : sample_inc;
            nxt_slot = slot_apply ? slot_mod[ast_pkg::SLOT_W-1:0] : slot_inc;
        end
        if (slot_apply) begin
            nxt_slot_adj = '0;
            nxt_tick_adj = '0;
            nxt_man_pend = 1'b0;
            nxt_trk_pend = 1'b0;
            nxt_done = is_trk ? (slot_adj_ff != '0) : 1'b1;
            if (is_acq) begin
                nxt_acq_done = 1'b1;
            end
        end
        // track correction at each second pulse
        s_now = $signed({2'b00, sample_ff});
        corr = (s_now >= ast_pkg::TRACK_LO && s_now < ast_pkg::TRACK_HI) ? ast_pkg::TRACK_MID - s_now : -s_now;
        max_s = $signed({2'b00, max_ff[ast_pkg::SAMPLE_W-1:0]});
        if (corr > max_s) begin
            corr = max_s;
        end else if (corr < -max_s) begin
            corr = -max_s;
        end
        if (utc_rise) begin
            nxt_capt = '0;
            nxt_capt[ast_pkg::CAPT_SLOT_LSB +: ast_pkg::SLOT_W] = slot_ff;
            nxt_capt[ast_pkg::SAMPLE_W-1:0] = sample_ff;
            if (is_trk) begin
                nxt_trk_corr = corr;
                nxt_trk_pend = 1'b1;
            end
        end
        if (ctrl_ff[ast_pkg::CTRL_SLEEP_BIT] && tick_ff && !rx_slot_active
            && sample_ff == doze_ff[ast_pkg::SAMPLE_W-1:0]) begin
            nxt_sleep = 1'b1;
        end
        if (tick_ff && sample_ff == wake_ff[ast_pkg::SAMPLE_W-1:0]) begin
            nxt_sleep = 1'b0;
        end
        if (!ctrl_ff[ast_pkg::CTRL_SLEEP_BIT]) begin
            nxt_sleep = 1'b0;
        end
        // Host writes win over same-cycle clears
        if (bus_req.wr_en) begin
            unique case (bus_req.addr)
                ast_pkg::ADDR_CTRL: nxt_ctrl = bus_req.wdata[7:0];
                ast_pkg::ADDR_DOZE: nxt_doze = bus_req.wdata;
                ast_pkg::ADDR_WAKE: nxt_wake = bus_req.wdata;
                ast_pkg::ADDR_SLOT_ADJ: nxt_slot_adj = bus_req.wdata;
                ast_pkg::ADDR_TICK_ADJ: begin
                    nxt_tick_adj = bus_req.wdata;
                    nxt_man_pend = 1'b1;
                end
                ast_pkg::ADDR_TRIG: nxt_trig = bus_req.wdata;
                ast_pkg::ADDR_MAX_NUDGE: nxt_max = bus_req.wdata;
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        nxt_rsp.rvalid = bus_req.rd_en;
        nxt_rsp.rdata = '0;
        if (bus_req.rd_en && bus_req.addr == ast_pkg::ADDR_LIVE) begin
            nxt_rsp.rdata[ast_pkg::CAPT_SLOT_LSB +: ast_pkg::SLOT_W] = slot_ff;
            nxt_rsp.rdata[ast_pkg::SAMPLE_W-1:0] = sample_ff;
        end else if (bus_req.rd_en && bus_req.addr == ast_pkg::ADDR_CAPT) begin
            nxt_rsp.rdata = capt_ff;
        end
        // pulse during first sample of slot
        if (ctrl_ff[ast_pkg::CTRL_PIN_BIT]) begin
            nxt_pin_o = 1'b0;
            nxt_pin_oe = (nxt_sample == '0);
        end else begin
            nxt_pin_o = (nxt_sample != '0);
            nxt_pin_oe = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sample_ff <= '0;
            slot_ff <= '0;
            ctrl_ff <= ast_pkg::CTRL_RESET;
            doze_ff <= ast_pkg::WORD_RESET;
            wake_ff <= ast_pkg::WORD_RESET;
            slot_adj_ff <= ast_pkg::WORD_RESET;
            tick_adj_ff <= ast_pkg::WORD_RESET;
            trig_ff <= ast_pkg::WORD_RESET;
            max_ff <= ast_pkg::WORD_RESET;
            capt_ff <= '0;
            man_pend_ff <= 1'b0;
            acq_done_ff <= 1'b0;
            trk_pend_ff <= 1'b0;
            trk_corr_ff <= '0;
            sleep_ff <= 1'b0;
            done_ff <= 1'b0;
            pin_o_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
            rsp_ff <= '0;
        end else begin
            sample_ff <= nxt_sample;
            slot_ff <= nxt_slot;
            ctrl_ff <= nxt_ctrl;
            doze_ff <= nxt_doze;
            wake_ff <= nxt_wake;
            slot_adj_ff <= nxt_slot_adj;
            tick_adj_ff <= nxt_tick_adj;
            trig_ff <= nxt_trig;
            max_ff <= nxt_max;
            capt_ff <= nxt_capt;
            man_pend_ff <= nxt_man_pend;
            acq_done_ff <= nxt_acq_done;
            trk_pend_ff <= nxt_trk_pend;
            trk_corr_ff <= nxt_trk_corr;
            sleep_ff <= nxt_sleep;
            done_ff <= nxt_done;
            pin_o_ff <= nxt_pin_o;
            pin_oe_ff <= nxt_pin_oe;
            rsp_ff <= nxt_rsp;
        end
    end

    assign bus_rsp = rsp_ff;
    assign slot_pulse_n_out_o = pin_o_ff;
    assign slot_pulse_n_out_oe = pin_oe_ff;
    assign rx_sleep = sleep_ff;
    assign nudge_done = done_ff;
    chk_sample_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        tick_ff && sample_ff == ast_pkg::SAMPLE_LAST && !apply |=> sample_ff == '0)
        else $error("sample counter did not wrap to zero");
    chk_sample_step: assert property (@(posedge clk) disable iff (!rst_n)
        !tick_ff |=> $stable(sample_ff))
        else $error("sample counter moved without a tick");
    chk_slot_range: assert property (@(posedge clk) disable iff (!rst_n)
        slot_ff <= ast_pkg::SLOT_LAST)
        else $error("slot counter out of range");
    chk_slot_advance: assert property (@(posedge clk) disable iff (!rst_n)
        tick_ff && sample_ff != ast_pkg::SAMPLE_LAST && !slot_apply |=> $stable(slot_ff))
        else $error("slot counter moved mid-slot");
    chk_pulse_low: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && !$past(ctrl_ff[ast_pkg::CTRL_PIN_BIT]) |-> (slot_pulse_n_out_o == (sample_ff != '0)))
        else $error("slot pulse level wrong");
    chk_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) && $past(ctrl_ff[ast_pkg::CTRL_PIN_BIT])
            |-> !slot_pulse_n_out_o && (slot_pulse_n_out_oe == (sample_ff == '0)))
        else $error("open-drain pin drove high");
    chk_capture_edge: assert property (@(posedge clk) disable iff (!rst_n)
        utc_rise |=> capt_ff == {4'h0, $past(slot_ff), 5'h00, $past(sample_ff)})
        else $error("capture missed second pulse");
    chk_nudge_clear: assert property (@(posedge clk) disable iff (!rst_n)
        slot_apply && !bus_req.wr_en |=> slot_adj_ff == '0 && tick_adj_ff == '0)
        else $error("adjustments not cleared after nudge");
    chk_sleep_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_ff[ast_pkg::CTRL_SLEEP_BIT] |=> !rx_sleep)
        else $error("receiver dozing with sleep disabled");
    chk_auto_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        trig && is_trk && !trk_pend_ff |=> sample_ff == $past(sample_inc))
        else $error("sample adjusted without a pending track nudge");
endmodule

// File: logic/ast_pkg.sv
package ast_pkg;
    // Register addresses on the serial control bus
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_LIVE = 8'h11;
    localparam logic [7:0] ADDR_DOZE = 8'h12;
    localparam logic [7:0] ADDR_WAKE = 8'h13;
    localparam logic [7:0] ADDR_CAPT = 8'h14;
    localparam logic [7:0] ADDR_SLOT_ADJ = 8'h15;
    localparam logic [7:0] ADDR_TICK_ADJ = 8'h16;
    localparam logic [7:0] ADDR_TRIG = 8'h17;
    localparam logic [7:0] ADDR_MAX_NUDGE = 8'h18;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Timer control fields
    localparam int CTRL_PIN_BIT = 7;
    localparam int CTRL_SLEEP_BIT = 2;
    localparam int CTRL_MODE_LSB = 0;
    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_ACQUIRE = 2'h1;
    localparam logic [1:0] MODE_TRACK = 2'h2;
    // Counter geometry
    localparam int SAMPLE_W = 11;
    localparam int SLOT_W = 12;
    localparam logic [10:0] SAMPLE_LAST = 11'h4ff;
    localparam logic [11:0] SLOT_LAST = 12'h8c9;
    localparam int SLOTS_PER_FRAME = 2250;
    localparam int SAMPLE_RATE_HZ = 48000;
    localparam int REF_HZ_DEFAULT = 2400000;
    // Auto-track window
    localparam logic signed [12:0] TRACK_LO = 13'sh0140;
    localparam logic signed [12:0] TRACK_HI = 13'sh03c0;
    localparam logic signed [12:0] TRACK_MID = 13'sh0280;
    // Capture word layout
    localparam int CAPT_SLOT_LSB = 16;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ast_bus_req_type;

    typedef struct packed {
        logic rvalid;
        logic [31:0] rdata;
    } ast_bus_rsp_type;
endpackage

// File: dv/ast_host_model.sv
`timescale 1ns/1ns
module ast_host_model (
    input wire logic clk,
    output ast_pkg::ast_bus_req_type bus_req
);
    initial begin
        bus_req = '0;
    end

    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        @(negedge clk);
        bus_req.wr_en = 1'b1;
        bus_req.addr = addr;
        bus_req.wdata = data;
        @(negedge clk);
        bus_req.wr_en = 1'b0;
        bus_req.addr = ~addr;
        bus_req.wdata = ~data;
    endtask

    task automatic rd(input logic [7:0] addr);
        @(negedge clk);
        bus_req.rd_en = 1'b1;
        bus_req.addr = addr;
        @(negedge clk);
        bus_req.rd_en = 1'b0;
        bus_req.addr = ~addr;
    endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam int TICK_CLK = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reference_clock_in = 1'b0;
    logic utc_second_pulse_in = 1'b0;
    logic rx_slot_active = 1'b0;
    ast_pkg::ast_bus_req_type bus_req;
    ast_pkg::ast_bus_rsp_type bus_rsp;
    logic pin_o;
    logic pin_oe;
    logic rx_sleep;
    logic nudge_done;
    int miscompares = 0;
    int compares = 0;
    logic [31:0] exp_q[$];
    logic [7:0] ctrl_exp = ast_pkg::CTRL_RESET;
    bit pin_chk = 1'b1;
    bit width_on = 1'b0;
    int low_cnt = 0;
    int adj2;

    always #20 clk = ~clk;
    // Reference runs at a quarter of clk, so one sample tick is eight clocks
    always #80 reference_clock_in = ~reference_clock_in;

    ast_slot_timer #(.REF_HZ(96000)) uut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rsp(bus_rsp),
        .reference_clock_in(reference_clock_in), .utc_second_pulse_in(utc_second_pulse_in),
        .rx_slot_active(rx_slot_active), .slot_pulse_n_out_o(pin_o), .slot_pulse_n_out_oe(pin_oe),
        .rx_sleep(rx_sleep), .nudge_done(nudge_done));
    ast_host_model host (.clk(clk), .bus_req(bus_req));

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    function automatic logic [31:0] word(input logic [11:0] slot, input logic [10:0] sample);
        return {4'h0, slot, 5'h00, sample};
    endfunction

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
        exp_q.push_back(exp);
        host.rd(addr);
    endtask

    // Pin checks pause while a new mode travels into the pin registers
    task automatic set_ctrl(input logic [7:0] v);
        pin_chk = 1'b0;
        host.wr(ast_pkg::ADDR_CTRL, {8'h00, v});
        ctrl_exp = v;
        repeat (2) @(negedge clk);
        pin_chk = 1'b1;
    endtask

    task automatic wait_out(input int sel, input logic lvl, input int bound);
        int n;
        n = 0;
        @(negedge clk);
        while (((sel == 0) ? nudge_done : rx_sleep) !== lvl && n < bound) begin
            @(negedge clk);
            n++;
        end
        if (n >= bound) cmp1(1'b0, 1'b1, "wait timed out");
    endtask

    task automatic stop_test();
        if (exp_q.size() != 0) miscompares++;
        $display("Compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(negedge clk) begin
        if (bus_rsp.rvalid === 1'b1) begin
            if (exp_q.size() == 0) cmp1(1'b1, 1'b0, "unexpected read answer");
            else cmp32(bus_rsp.rdata, exp_q.pop_front(), "read data");
        end
        if (rst_n === 1'b1 && pin_chk && ctrl_exp[7]) cmp1(pin_o, 1'b0, "open-drain level");
        if (rst_n === 1'b1 && pin_chk && !ctrl_exp[7]) cmp1(pin_oe, 1'b1, "push-pull enable");
        if (pin_oe === 1'b1 && pin_o === 1'b0) begin
            low_cnt++;
        end else begin
            if (width_on && low_cnt > 0) cmp32(32'(low_cnt), 32'(TICK_CLK), "slot pulse width");
            low_cnt = 0;
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        void'($urandom(90352));
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rd(ast_pkg::ADDR_CAPT, 32'h0);
        rd(8'h20, 32'h0);
        rd(ast_pkg::ADDR_CTRL, 32'h0);
        host.wr(8'h20, 16'hffff);
        set_ctrl(8'h00);
        host.wr(ast_pkg::ADDR_TRIG, 16'h0064);
        host.wr(ast_pkg::ADDR_SLOT_ADJ, 16'hffff);
        host.wr(ast_pkg::ADDR_TICK_ADJ, 16'h01f4);
        wait_out(0, 1'b1, 2000);
        rd(ast_pkg::ADDR_LIVE, word(12'd2249, 11'd601));
        // Reserved mode nudge; slot adjust was cleared so only the sample moves
        width_on = 1'b1;
        set_ctrl(8'h03);
        adj2 = $urandom_range(100) - 50;
        host.wr(ast_pkg::ADDR_TICK_ADJ, 16'(adj2));
        wait_out(0, 1'b1, 8000);
        rd(ast_pkg::ADDR_LIVE, word(12'd0, 11'(101 + adj2)));
        host.wr(ast_pkg::ADDR_DOZE, 16'h00c8);
        host.wr(ast_pkg::ADDR_WAKE, 16'h012c);
        set_ctrl(8'h04);
        wait_out(1, 1'b1, 2000);
        utc_second_pulse_in = 1'b1;
        // Doze is raised on the tick that also moves the sample from 200 to 201
        rd(ast_pkg::ADDR_LIVE, word(12'd0, 11'd201));
        repeat (4) @(negedge clk);
        rd(ast_pkg::ADDR_CAPT, word(12'd0, 11'd201));
        utc_second_pulse_in = 1'b0;
        wait_out(1, 1'b0, 1000);
        rd(ast_pkg::ADDR_LIVE, word(12'd0, 11'd301));
        // Acquire pulls the captured 201 out at trigger 400; doze at 350 is held off by a busy slot
        rx_slot_active = 1'b1;
        host.wr(ast_pkg::ADDR_DOZE, 16'h015e);
        set_ctrl(8'h05);
        host.wr(ast_pkg::ADDR_TRIG, 16'h0190);
        host.wr(ast_pkg::ADDR_TICK_ADJ, 16'h0030);
        wait_out(0, 1'b1, 2000);
        cmp1(rx_sleep, 1'b0, "doze while slot in use");
        rd(ast_pkg::ADDR_LIVE, word(12'd0, 11'd200));
        // Track clamps the -count correction to the limit of 7, slot adjust lands too
        set_ctrl(8'h02);
        host.wr(ast_pkg::ADDR_MAX_NUDGE, 16'h0007);
        host.wr(ast_pkg::ADDR_TRIG, 16'h0258);
        utc_second_pulse_in = 1'b1;
        repeat (4) @(negedge clk);
        utc_second_pulse_in = 1'b0;
        host.wr(ast_pkg::ADDR_SLOT_ADJ, 16'h0002);
        wait_out(0, 1'b1, 4000);
        rd(ast_pkg::ADDR_LIVE, word(12'd2, 11'd594));
        set_ctrl(8'h80);
        repeat (50) @(negedge clk);
        stop_test();
    end
endmodule
